// [core/ptb_pkg.sv]
// Purpose: Shared constants and types for the pairable timer bank
// Assumes: 32-bit Avalon-MM register bus, one clock domain
// Notes:   Each timer owns four word registers in a 16-byte slot
package ptb_pkg;

  localparam int NUM_TMR  = 8;
  localparam int NUM_PAIR = 4;
  localparam int CW       = 16;
  localparam int AW       = 7;

  // Register index inside a timer slot (byte address = slot*16 + index*4)
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_PER  = 2'h1;
  localparam logic [1:0] REG_CNT  = 2'h2;
  localparam logic [1:0] REG_STAT = 2'h3;

  // Control register bit positions
  localparam int CB_RUN       = 15;
  localparam int CB_IDLE_STOP = 13;
  localparam int CB_SRUN      = 12;
  localparam int CB_GATE      = 6;
  localparam int CB_PS        = 4;
  localparam int CB_JOIN      = 3;
  localparam int CB_CS        = 1;

  // Status register bit positions
  localparam int SB_FLAG = 0;
  localparam int SB_IE   = 1;

  // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] PS_TERM1   = 8'h00;
  localparam logic [7:0] PS_TERM8   = 8'h07;
  localparam logic [7:0] PS_TERM64  = 8'h3F;
  localparam logic [7:0] PS_TERM256 = 8'hFF;

  localparam logic [CW-1:0] PER_RST = 16'hFFFF;
  localparam logic [CW-1:0] CNT_RST = 16'h0000;

  typedef struct packed {
    logic       run;
    logic       idle_stop;
    logic       srun;
    logic       gate;
    logic [1:0] presc;
    logic       pair_join_bit;
    logic       cs;
  } ptb_ctl_type;

  localparam ptb_ctl_type CTL_RST = '0;

  typedef struct packed {
    logic tick;
    logic gate_fall;
  } ptb_evt_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } ptb_bus_type;

endpackage

// [core/ptb_tick.sv]
// Purpose: Counting-clock source for one timer: pin sync, gate, prescaler
// Assumes: ext and gate pins are asynchronous to core_clk_i
// Notes:   Emits a one-cycle tick per prescaled counting clock
`timescale 1ns/1ps
module ptb_tick
  import ptb_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire ptb_ctl_type ctl_i,
  input  wire logic        hold_i,
  input  wire logic        ext_pin_i,
  input  wire logic        gate_pin_i,
  output ptb_evt_type      evt_o
);

  logic [2:0]  ext_sync_ff;
  logic [2:0]  gate_sync_ff;
  logic [7:0]  pre_ff;
  ptb_evt_type evt_ff;
  logic [7:0]  nxt_pre;
  ptb_evt_type nxt_evt;
  logic [7:0]  term;
  logic        src;

  always_comb
  begin
    case (ctl_i.presc)
      2'h0:    term = PS_TERM1;
      2'h1:    term = PS_TERM8;
      2'h2:    term = PS_TERM64;
      default: term = PS_TERM256;
    endcase
    // External clock counts rising edges; internal clock may be gated
    if (ctl_i.cs)
      src = ext_sync_ff[1] & ~ext_sync_ff[2];
    else
      src = ~ctl_i.gate | gate_sync_ff[1];
    nxt_pre = pre_ff;
    nxt_evt = '0;
    if (!ctl_i.run || hold_i)
      nxt_pre = 8'h00;
    else if (src)
    begin
      if (pre_ff == term)
      begin
        nxt_pre      = 8'h00;
        nxt_evt.tick = 1'b1;
      end
      else
        nxt_pre = pre_ff + 8'h01;
    end
    nxt_evt.gate_fall = ctl_i.run & ctl_i.gate & ~ctl_i.cs
                        & gate_sync_ff[2] & ~gate_sync_ff[1];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ext_sync_ff  <= 3'h0;
      gate_sync_ff <= 3'h0;
      pre_ff       <= 8'h00;
      evt_ff       <= '0;
    end
    else
    begin
      ext_sync_ff  <= {ext_sync_ff[1:0], ext_pin_i};
      gate_sync_ff <= {gate_sync_ff[1:0], gate_pin_i};
      pre_ff       <= nxt_pre;
      evt_ff       <= nxt_evt;
    end
  end

  assign evt_o = evt_ff;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_PS_TERM: assert property (evt_ff.tick |-> $past(pre_ff) == $past(term))
    else $error("tick without prescaler terminal count");
  AST_HOLD_STOP: assert property ((hold_i || !ctl_i.run) |=> !evt_ff.tick)
    else $error("tick while held or stopped");

endmodule

// [core/ptb_timer_bank.sv]
// Purpose: Bank of eight 16-bit timers in four joinable pairs
// Assumes: Avalon-MM slave; idle_i and sleep_i come from the local power
//          controller on core_clk_i; ext_clk_i and gate_i are pins
// Notes:   Each timer slot holds control, period, count and status words
// Functional notes
// - Pair runs joined 32-bit or two 16-bit
// - Separate timers keep all synchronous 16-bit modes
// - Joined pair: 32-bit timer or synchronous counter
// - Joined 32-bit period match raises interrupt request
// - Only pair zero feeds capture/compare time bases
// - Pair zero triggers first converter
// - Pair one triggers second converter
// - Every timer: synchronous timer or counter
// - Even timer low word, odd timer high
// - Joined: odd control ignored, even control used
// - Even clock/gate, odd flag reports match
// - Period high from odd, low from even
// - Count high in odd, low in even
// - Two-bit prescale field per timer
// - Only pair zero timers request DMA
// - Configurable running in idle and sleep
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module ptb_timer_bank
  import ptb_pkg::*;
(
  input  wire logic          core_clk_i,
  input  wire logic          rst_i,
  input  wire logic [AW-1:0] avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [31:0]   avs_writedata_i,
  input  wire logic [3:0]    avs_byteenable_i,
  output logic [31:0]        avs_readdata_o,
  output logic               avs_waitrequest_o,
  input  wire logic [7:0]    ext_clk_i,
  input  wire logic [7:0]    gate_i,
  input  wire logic          idle_i,
  input  wire logic          sleep_i,
  output logic [7:0]         irq_req_o,
  output logic [CW-1:0]      cmp_base0_o,
  output logic [CW-1:0]      cmp_base1_o,
  output logic               adc1_trig_o,
  output logic               adc2_trig_o,
  output logic [1:0]         dma_req_o
);

  ptb_ctl_type   ctl_ff   [NUM_TMR];
  logic [CW-1:0] per_ff   [NUM_TMR];
  logic [CW-1:0] cnt_ff   [NUM_TMR];
  logic [7:0]    flag_ff;
  logic [7:0]    ie_ff;
  ptb_bus_type   bus_ff;
  logic          wait_ff;
  logic [31:0]   rdata_ff;
  logic [7:0]    irq_ff;
  logic [1:0]    adc_ff;
  logic [1:0]    dma_ff;

  ptb_ctl_type   nxt_ctl  [NUM_TMR];
  logic [CW-1:0] nxt_per  [NUM_TMR];
  logic [CW-1:0] nxt_cnt  [NUM_TMR];
  logic [7:0]    nxt_flag;
  logic [7:0]    nxt_ie;
  ptb_bus_type   nxt_bus;
  logic          nxt_wait;
  logic [31:0]   nxt_rdata;

  ptb_evt_type   evt      [NUM_TMR];
  logic [7:0]    hold;
  logic [7:0]    match;
  logic [7:0]    gate_ev;
  logic [2:0]    idx;
  logic [1:0]    rsel;
  logic          wr_take;
  logic [15:0]   wmask;
  logic [15:0]   wdat;

  function automatic logic [15:0] ctl_word(ptb_ctl_type c);
    logic [15:0] w;
    w            = 16'h0000;
    w[CB_RUN]    = c.run;
    w[CB_IDLE_STOP] = c.idle_stop;
    w[CB_SRUN]   = c.srun;
    w[CB_GATE]   = c.gate;
    w[CB_PS+:2]  = c.presc;
    w[CB_JOIN]   = c.pair_join_bit;
    w[CB_CS]     = c.cs;
    return w;
  endfunction

  function automatic ptb_ctl_type word_ctl(logic [15:0] w, logic odd);
    ptb_ctl_type c;
    c.run   = w[CB_RUN];
    c.idle_stop = w[CB_IDLE_STOP];
    c.srun  = w[CB_SRUN];
    c.gate  = w[CB_GATE];
    c.presc = w[CB_PS+:2];
    c.pair_join_bit = w[CB_JOIN] & ~odd;
    c.cs    = w[CB_CS];
    return c;
  endfunction

  assign idx     = avs_address_i[6:4];
  assign rsel    = avs_address_i[3:2];
  assign wr_take = (bus_ff == BUS_ACK) & avs_write_i;
  assign wmask   = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wdat    = avs_writedata_i[15:0];

  // One counting-clock source per timer
  for (genvar t = 0; t < NUM_TMR; t++)
  begin : g_tick
    assign hold[t] = (idle_i & ctl_ff[t].idle_stop)
                     | (sleep_i & ~ctl_ff[t].srun);
    ptb_tick u_tick (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .ctl_i      (ctl_ff[t]),
      .hold_i     (hold[t]),
      .ext_pin_i  (ext_clk_i[t]),
      .gate_pin_i (gate_i[t]),
      .evt_o      (evt[t])
    );
  end

  // Bus handshake: one wait cycle, then a single acknowledge cycle
  always_comb
  begin
    nxt_bus   = bus_ff;
    nxt_wait  = 1'b1;
    nxt_rdata = rdata_ff;
    case (bus_ff)
      BUS_IDLE:
      begin
        if (avs_read_i || avs_write_i)
        begin
          nxt_bus   = BUS_ACK;
          nxt_wait  = 1'b0;
          nxt_rdata = 32'h0000_0000;
          if (rsel == REG_CTRL)
            nxt_rdata[15:0] = ctl_word(ctl_ff[idx]);
          else if (rsel == REG_PER)
            nxt_rdata[15:0] = per_ff[idx];
          else if (rsel == REG_CNT)
            nxt_rdata[15:0] = cnt_ff[idx];
          else
          begin
            nxt_rdata[SB_FLAG] = flag_ff[idx];
            nxt_rdata[SB_IE]   = ie_ff[idx];
          end
        end
      end
      default:
        nxt_bus = BUS_IDLE;
    endcase
  end

  // Counting, pairing and register writes
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_ctl = ctl_ff;
    nxt_per = per_ff;
    nxt_ie  = ie_ff;
    match   = 8'h00;
    gate_ev = 8'h00;
    for (int p = 0; p < NUM_PAIR; p++)
    begin
      if (ctl_ff[2*p].pair_join_bit)
      begin
        // Even timer's clock and gate drive the joined count
        if (evt[2*p].tick)
        begin
          if ({cnt_ff[2*p+1], cnt_ff[2*p]} == {per_ff[2*p+1], per_ff[2*p]})
          begin
            {nxt_cnt[2*p+1], nxt_cnt[2*p]} = 32'h0000_0000;
            match[2*p+1] = 1'b1;
          end
          else
            {nxt_cnt[2*p+1], nxt_cnt[2*p]} =
              32'({cnt_ff[2*p+1], cnt_ff[2*p]} + 32'h0000_0001);
        end
        gate_ev[2*p+1] = evt[2*p].gate_fall;
      end
      else
      begin
        for (int h = 0; h < 2; h++)
        begin
          if (evt[2*p+h].tick)
          begin
            if (cnt_ff[2*p+h] == per_ff[2*p+h])
            begin
              nxt_cnt[2*p+h] = CNT_RST;
              match[2*p+h]   = 1'b1;
            end
            else
              nxt_cnt[2*p+h] = cnt_ff[2*p+h] + 16'h0001;
          end
          gate_ev[2*p+h] = evt[2*p+h].gate_fall;
        end
      end
    end
    // Software writes win over counting on the count register
    if (wr_take)
    begin
      if (rsel == REG_CTRL)
        nxt_ctl[idx] = word_ctl((ctl_word(ctl_ff[idx]) & ~wmask) | (wdat & wmask), idx[0]);
      else if (rsel == REG_PER)
        nxt_per[idx] = (per_ff[idx] & ~wmask) | (wdat & wmask);
      else if (rsel == REG_CNT)
        nxt_cnt[idx] = (cnt_ff[idx] & ~wmask) | (wdat & wmask);
      else if (avs_byteenable_i[0])
        nxt_ie[idx] = avs_writedata_i[SB_IE];
    end
    // Flags: write one to clear, a hardware event in the same cycle wins
    nxt_flag = flag_ff;
    if (wr_take && rsel == REG_STAT && avs_byteenable_i[0] && avs_writedata_i[SB_FLAG])
      nxt_flag[idx] = 1'b0;
    nxt_flag = nxt_flag | match | gate_ev;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      for (int t = 0; t < NUM_TMR; t++)
      begin
        ctl_ff[t] <= CTL_RST;
        per_ff[t] <= PER_RST;
        cnt_ff[t] <= CNT_RST;
      end
      flag_ff  <= 8'h00;
      ie_ff    <= 8'h00;
      bus_ff   <= BUS_IDLE;
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      irq_ff   <= 8'h00;
      adc_ff   <= 2'h0;
      dma_ff   <= 2'h0;
    end
    else
    begin
      ctl_ff   <= nxt_ctl;
      per_ff   <= nxt_per;
      cnt_ff   <= nxt_cnt;
      flag_ff  <= nxt_flag;
      ie_ff    <= nxt_ie;
      bus_ff   <= nxt_bus;
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
      irq_ff   <= nxt_flag & nxt_ie;
      adc_ff   <= {match[3], match[1]};
      dma_ff   <= match[1:0] | gate_ev[1:0];
    end
  end

  assign avs_readdata_o    = rdata_ff;
  assign avs_waitrequest_o = wait_ff;
  assign irq_req_o         = irq_ff;
  assign cmp_base0_o       = cnt_ff[0];
  assign cmp_base1_o       = cnt_ff[1];
  assign adc1_trig_o       = adc_ff[0];
  assign adc2_trig_o       = adc_ff[1];
  assign dma_req_o         = dma_ff;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_JOIN_WRAP: assert property (ctl_ff[0].pair_join_bit && evt[0].tick
    && !wr_take && {cnt_ff[1], cnt_ff[0]} == {per_ff[1], per_ff[0]}
    |=> cnt_ff[0] == 16'h0000 && cnt_ff[1] == 16'h0000 && flag_ff[1])
    else $error("joined match did not clear count and set odd flag");
  AST_JOIN_CARRY: assert property (ctl_ff[0].pair_join_bit && evt[0].tick
    && !wr_take && cnt_ff[0] == 16'hFFFF
    && {cnt_ff[1], cnt_ff[0]} != {per_ff[1], per_ff[0]}
    |=> cnt_ff[0] == 16'h0000 && cnt_ff[1] == $past(cnt_ff[1]) + 16'h0001)
    else $error("low word overflow did not carry into high word");
  AST_ODD_IGNORED: assert property (ctl_ff[0].pair_join_bit && !evt[0].tick
    && !wr_take |=> $stable(cnt_ff[1]))
    else $error("odd timer counted on its own in joined mode");
  AST_EVEN_QUIET: assert property (ctl_ff[0].pair_join_bit && !flag_ff[0]
    && !wr_take |=> !flag_ff[0])
    else $error("even flag set in joined mode");
  AST_SEP_WRAP: assert property (!ctl_ff[2].pair_join_bit && evt[3].tick
    && !wr_take && cnt_ff[3] == per_ff[3] |=> cnt_ff[3] == 16'h0000 && flag_ff[3])
    else $error("separate match did not clear count and set flag");
  AST_SEP_INC: assert property (!ctl_ff[2].pair_join_bit && evt[3].tick
    && !wr_take && cnt_ff[3] != per_ff[3] |=> cnt_ff[3] == $past(cnt_ff[3]) + 16'h0001)
    else $error("separate timer did not count");
  AST_GATE_FLAG: assert property (!ctl_ff[6].pair_join_bit
    && evt[6].gate_fall |=> flag_ff[6])
    else $error("gate fall did not set flag");
  AST_ADC1: assert property (adc1_trig_o == $past(match[1]))
    else $error("first converter trigger missing");
  AST_ADC2: assert property (adc2_trig_o |-> $past(match[3]))
    else $error("second converter trigger without pair one match");
  AST_DMA: assert property (dma_req_o[0] |-> $past(match[0] || gate_ev[0]))
    else $error("dma request without timer zero event");
  AST_BUS_ACK: assert property ((avs_read_i || avs_write_i) && bus_ff == BUS_IDLE
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus acknowledge not one cycle after request");

  COV_JOIN_WRAP: cover property (ctl_ff[0].pair_join_bit && match[1]);
  COV_GATE_FALL: cover property (gate_ev[6]);
  COV_BUS_WRITE: cover property (wr_take && rsel == REG_CTRL);

endmodule

// [bench/test_ptb_timer_bank.sv]
// Purpose: Self-checking bench for the pairable timer bank
// Assumes: Avalon-MM master tasks on one 250 MHz clock
// Notes:   Trigger and DMA pulses are tallied by a monitor
`timescale 1ns/1ps
module test_ptb_timer_bank;
  import ptb_pkg::*;
  logic          clk        = 1'b0;
  logic          rst        = 1'b1;
  logic [AW-1:0] adr        = '0;
  logic          rd_en      = 1'b0;
  logic          wr_en      = 1'b0;
  logic [31:0]   wdat       = '0;
  logic [3:0]    be         = 4'hF;
  logic [31:0]   rdat;
  logic          wait_req;
  logic [7:0]    ext        = '0;
  logic [7:0]    gate       = '0;
  logic          idle       = 1'b0;
  logic          sleep      = 1'b0;
  logic [7:0]    irq;
  logic [CW-1:0] base0;
  logic [CW-1:0] base1;
  logic          adc1;
  logic          adc2;
  logic [1:0]    dma;
  int            fails      = 0;
  int            n_compared = 0;
  int            cyc        = 0;
  int            n_adc1     = 0;
  int            n_adc2     = 0;
  int            n_dma      = 0;
  logic [15:0]   v;

  ptb_timer_bank u_ptb_timer_bank (
    .core_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd_en),
    .avs_write_i(wr_en), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_req), .ext_clk_i(ext),
    .gate_i(gate), .idle_i(idle), .sleep_i(sleep), .irq_req_o(irq),
    .cmp_base0_o(base0), .cmp_base1_o(base1), .adc1_trig_o(adc1),
    .adc2_trig_o(adc2), .dma_req_o(dma)
  );

  always #2 clk = ~clk;

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (adc1 === 1'b1) n_adc1 <= n_adc1 + 1;
    if (adc2 === 1'b1) n_adc2 <= n_adc2 + 1;
    if (dma[1] === 1'b1 || dma[0] === 1'b1) n_dma <= n_dma + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      results();
    end
  end

  task automatic bw(input int t, input logic [1:0] r, input logic [15:0] d);
    @(posedge clk);
    adr   <= {t[2:0], r, 2'b00};
    wdat  <= {16'h0000, d};
    wr_en <= 1'b1;
    @(posedge clk);
    while (wait_req !== 1'b0)
      @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic br(input int t, input logic [1:0] r, output logic [15:0] d);
    @(posedge clk);
    adr   <= {t[2:0], r, 2'b00};
    rd_en <= 1'b1;
    @(posedge clk);
    while (wait_req !== 1'b0)
      @(posedge clk);
    d = rdat[15:0];
    rd_en <= 1'b0;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic rng(input logic [15:0] got, input int lo, input int hi, input string m);
    n_compared++;
    if (^got === 1'bx || got < lo || got > hi)
    begin
      fails++;
      $display("MISMATCH %0t %s: got %h outside %0d..%0d", $time, m, got, lo, hi);
    end
  endtask

  task automatic t_reset();
    for (int t = 0; t < 8; t++)
    begin
      br(t, REG_CTRL, v); chk(v, 16'h0000, "ctrl reset");
      br(t, REG_PER, v);  chk(v, PER_RST, "period reset");
      br(t, REG_CNT, v);  chk(v, CNT_RST, "count reset");
      br(t, REG_STAT, v); chk(v, 16'h0000, "status reset");
    end
    $display("test reset done");
  endtask

  task automatic t_join();
    bw(0, REG_CTRL, 16'h0008);
    bw(1, REG_CTRL, 16'h0070);
    bw(0, REG_PER, 16'h0100);
    bw(1, REG_PER, 16'h0001);
    bw(0, REG_CNT, 16'hFFFE);
    bw(1, REG_CNT, 16'h0000);
    bw(1, REG_STAT, 16'h0002);
    bw(0, REG_CTRL, 16'h8008);
    repeat (20) @(posedge clk);
    bw(0, REG_CTRL, 16'h0008);
    br(1, REG_CNT, v); chk(v, 16'h0001, "carry into high word");
    chk(base1, 16'h0001, "time base 1");
    br(0, REG_CNT, v); rng(v, 5, 48, "low word");
    chk(base0, v, "time base 0");
    br(1, REG_STAT, v); chk(v, 16'h0002, "no early match");
    bw(0, REG_PER, 16'h0040);
    bw(0, REG_CTRL, 16'h8008);
    repeat (80) @(posedge clk);
    bw(0, REG_CTRL, 16'h0008);
    br(1, REG_STAT, v); chk(v, 16'h0003, "odd flag on match");
    chk({15'h0, irq[1]}, 16'h0001, "odd irq");
    chk({15'h0, irq[0]}, 16'h0000, "even irq");
    br(0, REG_STAT, v); chk(v, 16'h0000, "even flag");
    br(1, REG_CNT, v); chk(v, 16'h0000, "wrapped high");
    br(0, REG_CNT, v); rng(v, 1, 64, "wrapped low");
    rng(16'(n_adc1), 1, 1, "adc1 trigger");
    rng(16'(n_dma), 1, 1, "dma request");
    bw(1, REG_STAT, 16'h0001);
    repeat (3) @(posedge clk);
    chk({15'h0, irq[1]}, 16'h0000, "irq cleared");
    $display("test join done");
  endtask

  task automatic t_sep();
    int d0;
    d0 = n_dma;
    bw(2, REG_CTRL, 16'h0000);
    bw(3, REG_PER, 16'h0003);
    bw(3, REG_STAT, 16'h0002);
    bw(3, REG_CTRL, 16'h8000);
    bw(2, REG_PER, 16'h0100);
    bw(2, REG_CTRL, 16'h8000);
    repeat (30) @(posedge clk);
    bw(3, REG_CTRL, 16'h0000);
    bw(2, REG_CTRL, 16'h0000);
    br(3, REG_STAT, v); chk(v, 16'h0003, "timer 3 flag");
    chk({15'h0, irq[3]}, 16'h0001, "timer 3 irq");
    rng(16'(n_adc2), 3, 12, "adc2 trigger");
    br(3, REG_CNT, v); rng(v, 0, 3, "timer 3 wraps");
    br(2, REG_CNT, v); rng(v, 16, 64, "timer 2 alone");
    br(2, REG_STAT, v); chk(v, 16'h0000, "timer 2 flag");
    rng(16'(n_dma - d0), 0, 0, "no dma from pair 1");
    bw(3, REG_STAT, 16'h0000);
    repeat (3) @(posedge clk);
    chk({15'h0, irq[3]}, 16'h0000, "irq masked");
    br(3, REG_STAT, v); chk(v, 16'h0001, "flag kept");
    $display("test separate done");
  endtask

  task automatic t_presc();
    int dv[4] = '{1, 8, 64, 256};
    for (int p = 0; p < 4; p++)
    begin
      bw(4, REG_CNT, 16'h0000);
      bw(4, REG_CTRL, 16'h8000 | 16'(p << 4));
      repeat (510) @(posedge clk);
      bw(4, REG_CTRL, 16'h0000);
      br(4, REG_CNT, v); rng(v, 505 / dv[p], 520 / dv[p] + 1, "prescale");
    end
    $display("test prescale done");
  endtask

  task automatic t_gate();
    bw(6, REG_CTRL, 16'h8040);
    repeat (10) @(posedge clk);
    gate[6] <= 1'b1;
    repeat (40) @(posedge clk);
    gate[6] <= 1'b0;
    repeat (10) @(posedge clk);
    bw(6, REG_CTRL, 16'h0000);
    br(6, REG_CNT, v); rng(v, 36, 44, "gated count");
    br(6, REG_STAT, v); chk(v, 16'h0001, "flag on gate fall");
    $display("test gate done");
  endtask

  task automatic t_ext();
    bw(5, REG_CTRL, 16'h8002);
    repeat (6)
    begin
      @(posedge clk);
      ext[5] <= 1'b1;
      repeat (4) @(posedge clk);
      ext[5] <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (8) @(posedge clk);
    br(5, REG_CNT, v); chk(v, 16'h0006, "pin edges");
    $display("test counter done");
  endtask

  task automatic t_idle();
    @(posedge clk);
    idle <= 1'b1;
    bw(7, REG_CTRL, 16'hA000);
    repeat (20) @(posedge clk);
    br(7, REG_CNT, v); chk(v, 16'h0000, "held in idle");
    idle <= 1'b0;
    sleep <= 1'b1;
    bw(7, REG_CTRL, 16'h9000);
    repeat (20) @(posedge clk);
    bw(7, REG_CTRL, 16'h0000);
    sleep <= 1'b0;
    br(7, REG_CNT, v); rng(v, 16, 30, "runs in sleep");
    $display("test power modes done");
  endtask

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_join();
    t_sep();
    t_presc();
    t_gate();
    t_ext();
    t_idle();
    results();
  end
endmodule
